// ---- rtl/cnf_fifo.sv ----
// Purpose: Common-clock native FIFO with build-time read modes, flags and register port
// Assumes: WR_DEPTH equals RD_DEPTH and is a power of two; count widths at most log2(depth)+1
// Notes: All outputs are registered; flags use next-state values so they track the edge
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ns
module cnf_fifo
  import cnf_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int WR_DEPTH = 16,
  parameter int RD_DEPTH = 16,
  parameter int WR_CNT_W = 5,
  parameter int RD_CNT_W = 5,
  parameter int READ_LATENCY = 1,
  parameter int PE_TYPE = 0,
  parameter int PE_ASSERT_VAL = 2,
  parameter int PE_NEGATE_VAL = 3,
  parameter int PF_TYPE = 0,
  parameter int PF_ASSERT_VAL = 14,
  parameter int PF_NEGATE_VAL = 13,
  parameter bit OVERFLOW_LOW = 1'h0,
  parameter bit UNDERFLOW_LOW = 1'h0,
  parameter bit VALID_LOW = 1'h0,
  parameter bit WR_ACK_LOW = 1'h0,
  parameter bit USE_DOUT_RST = 1'h1,
  parameter logic [DATA_W-1:0] DOUT_RST_VAL = '0,
  parameter int OUT_REG_OPT = 0,
  parameter int FT_COUNT_OPT = 0,
  parameter bit ECC_PIPE = 1'h0,
  parameter bit ECC_OPT = 1'h0,
  parameter bit RESET_SAFETY = 1'h0,
  parameter bit POWER_GATING = 1'h0,
  parameter bit FULL_RST_VAL = 1'h0,
  parameter bit RESET_SYNC = 1'h0
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [DATA_W-1:0] din,
  input wire logic rd_en,
  output logic [DATA_W-1:0] dout,
  output logic full,
  output logic empty,
  output logic prog_full,
  output logic prog_empty,
  output logic overflow,
  output logic underflow,
  output logic valid,
  output logic wr_ack,
  output logic [WR_CNT_W-1:0] wr_data_count,
  output logic [RD_CNT_W-1:0] rd_data_count,
  output logic rst_busy,
  output logic power_idle,
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [REG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [REG_DATA_W-1:0] reg_rdata,
  output logic irq
);
  localparam int PW = $clog2(WR_DEPTH);
  localparam int RPW = $clog2(RD_DEPTH);
  localparam int CW = PW + 1;
  localparam bit FALL = (READ_LATENCY == LAT_FALL_THROUGH);
  localparam bit PRELOAD_STAGE_SEL = (READ_LATENCY != LAT_STD);
  localparam bit CHECK_ON = ECC_OPT || (OUT_REG_OPT == 2);
  localparam int OUT_STAGE = ((PRELOAD_STAGE_SEL && !FALL) || OUT_REG_OPT == 1
                              || FT_COUNT_OPT == 2) ? 1 : 0;
  localparam int PIPE_STAGE = (ECC_PIPE && CHECK_ON) ? 1 : 0;
  localparam int EXTRA = OUT_STAGE + PIPE_STAGE;
  localparam int LAST = (EXTRA == 0) ? 0 : EXTRA - 1;
  localparam int PVW = EXTRA + 1;

  // Scales a full count down to a narrower bus by dropping low bits
  function automatic logic [THR_W-1:0] cnt_slice(input logic [CW-1:0] c, input int w);
    cnt_slice = (w >= CW) ? THR_W'(c) : THR_W'(c >> (CW - w));
  endfunction

  // Hysteresis: hit sets the flag, release clears it, otherwise it holds
  function automatic logic thr_flag(input logic cur, input logic hit, input logic release_c);
    thr_flag = hit ? 1'b1 : (release_c ? 1'b0 : cur);
  endfunction

  logic rst_s1;
  logic rst_s2;
  logic irst;
  logic [SAFETY_CNT_W-1:0] safe_cnt;
  logic [SAFETY_CNT_W-1:0] next_safe;
  logic [PW-1:0] wptr;
  logic [RPW-1:0] rptr;
  logic [CW-1:0] mcnt;
  logic [CW-1:0] next_mcnt;
  logic [CW-1:0] next_rcnt;
  logic hold;
  logic next_hold;
  logic mem_empty;
  logic mem_full;
  logic wr_ok;
  logic rd_take;
  logic ov_evt;
  logic un_evt;
  logic mem_en;
  logic [DATA_W-1:0] mem_q;
  logic mem_err;
  logic [DATA_W-1:0] pd [EXTRA+1];
  logic [EXTRA:0] pv;
  logic [DATA_W-1:0] src_d;
  logic src_v;
  logic dout_load;
  logic [DATA_W-1:0] dout_src;
  logic next_valid;
  logic next_empty;
  logic [EVT_W-1:0] status;
  logic [EVT_W-1:0] mask;
  logic [EVT_W-1:0] evt;
  logic [EVT_W-1:0] w1c;
  logic [EVT_W-1:0] next_status;
  logic [THR_W-1:0] pe_assert_reg;
  logic [THR_W-1:0] pe_negate_reg;
  logic [THR_W-1:0] pf_assert_reg;
  logic [THR_W-1:0] pf_negate_reg;
  logic [THR_W-1:0] pe_a;
  logic [THR_W-1:0] pe_n;
  logic [THR_W-1:0] pf_a;
  logic [THR_W-1:0] pf_n;
  logic [THR_W-1:0] wcnt18;
  logic [THR_W-1:0] rcnt18;
  logic next_pe;
  logic next_pf;
  logic [REG_DATA_W-1:0] level_word;
  logic [REG_DATA_W-1:0] rd_sel;

  // Reset path; the first stage feeds only the second
  always_ff @(posedge clk)
  begin
    rst_s1 <= rst;
    rst_s2 <= rst_s1;
  end
  assign irst = RESET_SYNC ? rst_s2 : rst;

  // Hold-off window keeps accesses out while storage settles after reset
  assign next_safe = (safe_cnt == '0) ? '0 : safe_cnt - 4'h1;
  always_ff @(posedge clk)
  begin
    if (irst)
    begin
      safe_cnt <= SAFETY_CYCLES;
      rst_busy <= RESET_SAFETY;
    end
    else
    begin
      safe_cnt <= next_safe;
      rst_busy <= RESET_SAFETY && (next_safe != '0);
    end
  end

  assign mem_empty = (mcnt == '0);
  assign mem_full = (mcnt == CW'(WR_DEPTH));
  assign wr_ok = wr_en && !mem_full && !rst_busy;
  assign rd_take = FALL ? (!mem_empty && (!hold || rd_en) && !rst_busy)
                        : (rd_en && !mem_empty && !rst_busy);
  assign ov_evt = wr_en && mem_full;
  assign un_evt = rd_en && (FALL ? !hold : mem_empty);
  assign next_mcnt = mcnt + CW'(wr_ok) - CW'(rd_take);
  assign next_hold = FALL && (rd_take || (hold && !rd_en));
  assign next_rcnt = (FALL && FT_COUNT_OPT == 1) ? next_mcnt + CW'(next_hold)
                                                 : next_mcnt;
  // Gating only lets the array see a cycle with real traffic
  assign mem_en = !POWER_GATING || wr_ok || rd_take;

  always_ff @(posedge clk)
  begin
    if (irst)
    begin
      wptr <= '0;
      rptr <= '0;
      mcnt <= '0;
      hold <= 1'b0;
    end
    else
    begin
      if (wr_ok)
        wptr <= wptr + PW'(1);
      if (rd_take)
        rptr <= rptr + RPW'(1);
      mcnt <= next_mcnt;
      hold <= next_hold;
    end
  end

  cnf_mem #(
    .DATA_W(DATA_W),
    .DEPTH(WR_DEPTH),
    .AW(PW),
    .CHECK(CHECK_ON)
  ) u_mem (
    .clk(clk),
    .en(mem_en),
    .we(wr_ok),
    .waddr(wptr),
    .wdata(din),
    .raddr(PW'(rptr)),
    .rdata(mem_q),
    .rerr(mem_err)
  );

  // Read pipeline for standard mode: output and check stages in series
  always_ff @(posedge clk)
  begin
    if (irst)
      pv <= '0;
    else
      pv <= PVW'({pv, rd_take});
    if (rd_take)
      pd[0] <= mem_q;
    for (int i = 1; i <= EXTRA; i++)
    begin
      if (pv[i-1])
        pd[i] <= pd[i-1];
    end
  end

  assign src_d = (EXTRA == 0) ? mem_q : pd[LAST];
  assign src_v = (EXTRA == 0) ? rd_take : pv[LAST];
  assign dout_load = FALL ? rd_take : src_v;
  assign dout_src = FALL ? mem_q : src_d;
  assign next_valid = FALL ? next_hold : src_v;
  assign next_empty = FALL ? !next_hold : (next_mcnt == '0);

  // The array has no reset, so only the output register can honour a reset value
  always_ff @(posedge clk)
  begin
    if (irst)
    begin
      if (USE_DOUT_RST)
        dout <= DOUT_RST_VAL;
    end
    else if (dout_load)
      dout <= dout_src;
  end

  // Threshold sources
  assign pe_a = (PE_TYPE >= THR_INPUT) ? pe_assert_reg : THR_W'(PE_ASSERT_VAL);
  assign pe_n = (PE_TYPE == THR_CONST) ? THR_W'(PE_ASSERT_VAL)
              : (PE_TYPE == THR_CONST_PAIR) ? THR_W'(PE_NEGATE_VAL)
              : (PE_TYPE == THR_INPUT) ? pe_assert_reg : pe_negate_reg;
  assign pf_a = (PF_TYPE >= THR_INPUT) ? pf_assert_reg : THR_W'(PF_ASSERT_VAL);
  assign pf_n = (PF_TYPE == THR_CONST) ? THR_W'(PF_ASSERT_VAL)
              : (PF_TYPE == THR_CONST_PAIR) ? THR_W'(PF_NEGATE_VAL)
              : (PF_TYPE == THR_INPUT) ? pf_assert_reg : pf_negate_reg;
  assign wcnt18 = THR_W'(next_mcnt);
  assign rcnt18 = THR_W'(next_rcnt);
  assign next_pe = (PE_TYPE != THR_NONE)
                   && thr_flag(prog_empty, rcnt18 <= pe_a, rcnt18 > pe_n);
  assign next_pf = (PF_TYPE != THR_NONE)
                   && thr_flag(prog_full, wcnt18 >= pf_a, wcnt18 < pf_n);

  always_ff @(posedge clk)
  begin
    if (irst)
    begin
      full <= FULL_RST_VAL;
      prog_full <= FULL_RST_VAL && (PF_TYPE != THR_NONE);
      empty <= 1'b1;
      prog_empty <= (PE_TYPE != THR_NONE);
      overflow <= OVERFLOW_LOW;
      underflow <= UNDERFLOW_LOW;
      valid <= VALID_LOW;
      wr_ack <= WR_ACK_LOW;
      wr_data_count <= '0;
      rd_data_count <= '0;
      power_idle <= 1'b0;
    end
    else
    begin
      full <= (next_mcnt == CW'(WR_DEPTH));
      prog_full <= next_pf;
      empty <= next_empty;
      prog_empty <= next_pe;
      overflow <= ov_evt ^ OVERFLOW_LOW;
      underflow <= un_evt ^ UNDERFLOW_LOW;
      valid <= next_valid ^ VALID_LOW;
      wr_ack <= wr_ok ^ WR_ACK_LOW;
      wr_data_count <= WR_CNT_W'(cnt_slice(next_mcnt, WR_CNT_W));
      rd_data_count <= RD_CNT_W'(cnt_slice(next_rcnt, RD_CNT_W));
      power_idle <= POWER_GATING && !wr_en && !rd_en;
    end
  end

  // Events and register port
  always_comb
  begin
    evt = '0;
    evt[EVT_OVERFLOW] = ov_evt;
    evt[EVT_UNDERFLOW] = un_evt;
    evt[EVT_CHECK_ERR] = mem_err && rd_take;
    evt[EVT_PF_RISE] = next_pf && !prog_full;
    evt[EVT_PE_RISE] = next_pe && !prog_empty;
  end

  // A set in the clearing cycle wins over the clear
  assign w1c = (reg_wr && reg_addr == ADDR_STATUS) ? reg_wdata[EVT_W-1:0] : '0;
  assign next_status = (status & ~w1c) | evt;
  assign level_word = REG_DATA_W'(rcnt18)
                    | (REG_DATA_W'({prog_empty, prog_full, empty, full}) << LEVEL_FLAG_LSB);
  assign rd_sel = (reg_addr == ADDR_STATUS) ? REG_DATA_W'(status)
                : (reg_addr == ADDR_MASK) ? REG_DATA_W'(mask)
                : (reg_addr == ADDR_PE_ASSERT) ? REG_DATA_W'(pe_assert_reg)
                : (reg_addr == ADDR_PE_NEGATE) ? REG_DATA_W'(pe_negate_reg)
                : (reg_addr == ADDR_PF_ASSERT) ? REG_DATA_W'(pf_assert_reg)
                : (reg_addr == ADDR_PF_NEGATE) ? REG_DATA_W'(pf_negate_reg)
                : (reg_addr == ADDR_LEVEL) ? level_word
                : '0;

  always_ff @(posedge clk)
  begin
    if (irst)
    begin
      status <= STATUS_RST;
      mask <= MASK_RST;
      pe_assert_reg <= THR_RST;
      pe_negate_reg <= THR_RST;
      pf_assert_reg <= THR_RST;
      pf_negate_reg <= THR_RST;
      reg_rdata <= '0;
      irq <= 1'b0;
    end
    else
    begin
      status <= next_status;
      if (reg_wr && reg_addr == ADDR_MASK)
        mask <= reg_wdata[EVT_W-1:0];
      if (reg_wr && reg_addr == ADDR_PE_ASSERT)
        pe_assert_reg <= reg_wdata[THR_W-1:0];
      if (reg_wr && reg_addr == ADDR_PE_NEGATE)
        pe_negate_reg <= reg_wdata[THR_W-1:0];
      if (reg_wr && reg_addr == ADDR_PF_ASSERT)
        pf_assert_reg <= reg_wdata[THR_W-1:0];
      if (reg_wr && reg_addr == ADDR_PF_NEGATE)
        pf_negate_reg <= reg_wdata[THR_W-1:0];
      reg_rdata <= reg_rd ? rd_sel : '0;
      irq <= |(next_status & mask);
    end
  end
endmodule

// ---- rtl/cnf_pkg.sv ----
// Purpose: Shared constants for the configurable native FIFO and its register port
// Assumes: One clock, synchronous active-high reset, plain register port with 32-bit data
// Notes: Notes on behaviour follow, one line per option
// Notes on behaviour
// - Overflow, underflow, valid and write-ack each have a polarity bit; 1 means active-low.
// - Read latency 0 is fall-through, 1 standard, 2 standard with output register.
// - Preload stage select is 0 only for plain standard read, else 1.
// - Programmable empty: none, constant, constant pair, register input, register pair.
// - Programmable full uses the same five-way threshold mode encoding.
// - Write and read depths are each configurable from 16 to 131072 entries.
// - Write and read occupancy count buses are each 1 to 18 bits wide.
// - With output reset enabled, read data takes its reset value; else unchanged.
// - Output register option 1 adds a stage after memory; 2 selects soft correction (here a parity check only, with no repair).
// - Fall-through count option 1 counts the held output word; 2 adds a register.
// - Correction pipeline option 1 adds one register stage on the read path.
// - Correction option 0 means none, 1 means check bits stored with each word.
// - Safety option 1 holds off reads and writes around reset entry and exit.
// - Power gating option 1 disables storage access while the buffer is idle.
// - Full flags show a configurable value of 0 or 1 during reset.
// - Reset synchroniser option 1 passes reset through two flops; 0 uses it directly.
package cnf_pkg;
  localparam int LAT_FALL_THROUGH = 0;
  localparam int LAT_STD = 1;
  localparam int LAT_STD_REG = 2;
  localparam int THR_NONE = 0;
  localparam int THR_CONST = 1;
  localparam int THR_CONST_PAIR = 2;
  localparam int THR_INPUT = 3;
  localparam int THR_INPUT_PAIR = 4;
  localparam int REG_ADDR_W = 4;
  localparam int REG_DATA_W = 32;
  localparam int THR_W = 18;
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h1;
  localparam logic [3:0] ADDR_PE_ASSERT = 4'h2;
  localparam logic [3:0] ADDR_PE_NEGATE = 4'h3;
  localparam logic [3:0] ADDR_PF_ASSERT = 4'h4;
  localparam logic [3:0] ADDR_PF_NEGATE = 4'h5;
  localparam logic [3:0] ADDR_LEVEL = 4'h6;
  localparam int EVT_W = 5;
  localparam int EVT_OVERFLOW = 0;
  localparam int EVT_UNDERFLOW = 1;
  localparam int EVT_CHECK_ERR = 2;
  localparam int EVT_PF_RISE = 3;
  localparam int EVT_PE_RISE = 4;
  localparam logic [EVT_W-1:0] STATUS_RST = 5'h00;
  localparam logic [EVT_W-1:0] MASK_RST = 5'h00;
  localparam logic [THR_W-1:0] THR_RST = 18'h00000;
  localparam int LEVEL_FLAG_LSB = 24;
  localparam int SAFETY_CNT_W = 4;
  localparam logic [SAFETY_CNT_W-1:0] SAFETY_CYCLES = 4'h8;
endpackage

// ---- rtl/cnf_mem.sv ----
// Purpose: Storage array with optional parity check bit per word
// Assumes: Synchronous write, asynchronous read, one clock
// Notes: Parity detects single-bit upsets only; it does not repair them
`timescale 1ns/1ns
module cnf_mem
#(
  parameter int DATA_W = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4,
  parameter bit CHECK = 1'h0
)
(
  input wire logic clk,
  input wire logic en,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DATA_W-1:0] rdata,
  output logic rerr
);
  logic [DATA_W-1:0] mem [DEPTH];
  logic par [DEPTH];
  logic rpar;

  always_ff @(posedge clk)
  begin
    if (en && we)
    begin
      mem[waddr] <= wdata;
      par[waddr] <= ^wdata;
    end
  end

  assign rdata = mem[raddr];
  assign rpar = par[raddr];
  assign rerr = CHECK && en && (rpar != ^rdata);
endmodule

// ---- testbench/cnf_fifo_properties.sv ----
// Purpose: Port-level properties of cnf_fifo
// Assumes: Standard read with latency 1, one clock
// Notes: Flags are judged at their configured polarity
`timescale 1ns/1ns
module cnf_chk
#(
  parameter int WR_DEPTH = 16,
  parameter int WR_CNT_W = 5,
  parameter bit OVERFLOW_LOW = 1'h0,
  parameter bit UNDERFLOW_LOW = 1'h0,
  parameter bit VALID_LOW = 1'h0,
  parameter bit WR_ACK_LOW = 1'h0,
  parameter bit FULL_RST_VAL = 1'h0,
  parameter int DATA_W = 8,
  parameter logic [DATA_W-1:0] DOUT_RST_VAL = '0
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic full,
  input wire logic empty,
  input wire logic overflow,
  input wire logic underflow,
  input wire logic valid,
  input wire logic wr_ack,
  input wire logic [DATA_W-1:0] dout,
  input wire logic [WR_CNT_W-1:0] wr_data_count
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_wr_refused;
    wr_en && full;
  endsequence
  sequence s_rd_taken;
    rd_en && !empty;
  endsequence
  a_full_count: assert property (full == (wr_data_count == WR_CNT_W'(WR_DEPTH)))
    else $error("full disagrees with write count");
  a_ovf_on_full: assert property (s_wr_refused |=> overflow == !OVERFLOW_LOW)
    else $error("overflow missing");
  a_ovf_quiet: assert property (!(wr_en && full) |=> overflow == OVERFLOW_LOW)
    else $error("overflow without cause");
  a_udf_on_empty: assert property (rd_en && empty |=> underflow == !UNDERFLOW_LOW)
    else $error("underflow missing");
  a_full_holds: assert property (s_wr_refused ##0 !rd_en |=> $stable(wr_data_count) && full)
    else $error("refused write changed the contents");
  a_ack_counts: assert property (wr_en && !full && !rd_en |=>
    wr_ack == !WR_ACK_LOW && wr_data_count == $past(wr_data_count) + 1'b1)
    else $error("accepted write not acknowledged");
  a_read_valid: assert property (s_rd_taken |=> valid == !VALID_LOW)
    else $error("read word not marked valid");
  a_valid_quiet: assert property (!(rd_en && !empty) |=> valid == VALID_LOW)
    else $error("valid without read");
  a_dout_rst_val: assert property ($fell(rst) |-> dout == DOUT_RST_VAL)
    else $error("read data not at reset value");
  a_full_rst_val: assert property ($fell(rst) |-> full == FULL_RST_VAL && empty)
    else $error("full flags wrong after reset");
endmodule
bind cnf_fifo cnf_chk #(.WR_DEPTH(WR_DEPTH), .WR_CNT_W(WR_CNT_W), .OVERFLOW_LOW(OVERFLOW_LOW),
  .UNDERFLOW_LOW(UNDERFLOW_LOW), .VALID_LOW(VALID_LOW), .WR_ACK_LOW(WR_ACK_LOW),
  .FULL_RST_VAL(FULL_RST_VAL), .DATA_W(DATA_W), .DOUT_RST_VAL(DOUT_RST_VAL)) chk_u (
  .clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .full(full), .empty(empty),
  .overflow(overflow), .underflow(underflow), .valid(valid), .wr_ack(wr_ack), .dout(dout),
  .wr_data_count(wr_data_count));

// ---- testbench/cnf_client.sv ----
// Purpose: Writing and reading client in front of cnf_fifo
// Assumes: Wants from the bench are taken one edge late
// Notes: Slow mode drops requests on random cycles
`timescale 1ns/1ns
module cnf_client
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_want,
  input wire logic rd_want,
  input wire logic slow,
  input wire logic [31:0] rnd,
  output logic wr_en = 1'b0,
  output logic [7:0] din = 8'h00,
  output logic rd_en = 1'b0
);
  // Data moves every cycle so a stale word never passes for a write
  always @(posedge clk)
  begin
    wr_en <= !rst && wr_want && !(slow && rnd[0]);
    rd_en <= !rst && rd_want && !(slow && rnd[1]);
    din <= rnd[15:8];
  end
endmodule

// ---- testbench/configurable_native_fifo_tb.sv ----
// Purpose: Self-checking bench for cnf_fifo
// Assumes: Depth 16, standard read, overflow active low
// Notes: Expected results are queued at the edge and compared at the falling edge
`timescale 1ns/1ns
module configurable_native_fifo_tb;
  import cnf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_want = 1'b0;
  logic rd_want = 1'b0;
  logic slow = 1'b0;
  logic [31:0] rs = 32'h3EFD48CB;
  logic wr_en, rd_en, full, empty, prog_full, prog_empty, overflow, underflow, valid, wr_ack, irq;
  logic [7:0] din, dout;
  logic [4:0] wcnt, rcnt;
  logic rst_busy, power_idle;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] dq[$];
  logic [31:0] rq[$];
  logic [10:0] eq[$];
  logic [4:0] cnt = 5'h00;
  logic [17:0] thr = 18'h0;
  int n_fail = 0;
  int checks = 0;
  int n_op = 0;
  always #25 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge clk)
    rs <= lfsr(rs);
  cnf_fifo #(.PE_TYPE(THR_INPUT), .PF_TYPE(THR_CONST), .PF_ASSERT_VAL(14),
    .OVERFLOW_LOW(1'h1), .DOUT_RST_VAL(8'hA5)) dut_u (
    .clk(clk), .rst(rst), .wr_en(wr_en), .din(din), .rd_en(rd_en), .dout(dout),
    .full(full), .empty(empty), .prog_full(prog_full), .prog_empty(prog_empty),
    .overflow(overflow), .underflow(underflow), .valid(valid), .wr_ack(wr_ack),
    .wr_data_count(wcnt), .rd_data_count(rcnt), .rst_busy(rst_busy), .power_idle(power_idle),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));
  cnf_client cl_u (.clk(clk), .rst(rst), .wr_want(wr_want), .rd_want(rd_want), .slow(slow),
    .rnd(rs), .wr_en(wr_en), .din(din), .rd_en(rd_en));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    #1;
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Requests seen at this edge become notes of what must show after it
  always @(posedge clk)
  begin : note
    logic aw, ar;
    aw = wr_en && cnt != 5'h10;
    ar = rd_en && cnt != 5'h00;
    if (rst)
    begin
      dq.delete();
      eq.delete();
      cnt = 5'h00;
      thr = 18'h0;
    end
    else
    begin
      if (wr_en || rd_en)
        n_op++;
      if (aw)
        dq.push_back(din);
      cnt = cnt + 5'(aw) - 5'(ar);
      // Threshold in force before this edge judges the count after it
      eq.push_back({(cnt <= thr), cnt, reg_rd, aw, wr_en && !aw, rd_en && !ar, ar});
      if (reg_wr && reg_addr == ADDR_PE_ASSERT)
        thr = reg_wdata[17:0];
    end
  end
  always @(negedge clk)
  begin : watch
    logic [10:0] e;
    if (eq.size() > 0)
    begin
      e = eq.pop_front();
      chk({wr_ack, overflow, underflow, valid}, e[3:0] ^ 4'h4);
      chk({wcnt, rcnt}, {e[9:5], e[9:5]});
      chk({full, empty}, {e[9:5] == 5'h10, e[9:5] == 5'h00});
      chk({prog_full, prog_empty}, {e[9:5] >= 5'h0E, e[10]});
      if (e[0])
        chk(dout, dq.pop_front());
      chk(reg_rdata, e[4] ? rq.pop_front() : 32'h0);
      chk({rst_busy, power_idle}, 32'h0);
    end
  end
  task automatic reg_w(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_r(input logic [3:0] a, input logic [31:0] x);
    rq.push_back(x);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  // Partner requests lag the wants, so a run may overshoot n by a request or two
  task automatic run(input logic w, input logic r, input logic s, input int n);
    int t;
    t = n_op + n;
    @(posedge clk);
    wr_want <= w;
    rd_want <= r;
    slow <= s;
    for (int i = 0; i < 8 * n && n_op < t; i++)
      @(posedge clk);
    wr_want <= 1'b0;
    rd_want <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic results;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #(50 * 6000);
    n_fail++;
    results();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    chk({dout, full}, 9'h14A);
    reg_r(ADDR_STATUS, 32'h0);
    reg_r(ADDR_MASK, 32'h0);
    reg_w(4'hF, 32'hFFFFFFFF);
    reg_r(4'hF, 32'h0);
    reg_w(ADDR_PE_ASSERT, 32'h2);
    reg_r(ADDR_PE_ASSERT, 32'h2);
    reg_w(ADDR_MASK, 32'h3);
    run(1'b0, 1'b1, 1'b0, 1);
    chk(irq, 1'b1);
    reg_r(ADDR_STATUS, 32'h2);
    reg_w(ADDR_STATUS, 32'h2);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    run(1'b1, 1'b0, 1'b1, 20);
    chk(irq, 1'b1);
    reg_r(ADDR_LEVEL, 32'h05000010);
    reg_w(ADDR_LEVEL, 32'h0);
    reg_r(ADDR_LEVEL, 32'h05000010);
    reg_r(ADDR_STATUS, 32'h09);
    run(1'b0, 1'b1, 1'b0, 20);
    reg_r(ADDR_STATUS, 32'h1B);
    reg_w(ADDR_STATUS, 32'h1F);
    reg_r(ADDR_STATUS, 32'h0);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    run(1'b1, 1'b1, 1'b1, 300);
    run(1'b1, 1'b0, 1'b0, 6);
    run(1'b0, 1'b1, 1'b0, 1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk({dout, full, empty}, 10'h295);
    run(1'b1, 1'b1, 1'b0, 4);
    results();
  end
endmodule
